//--- crs_core.sv
// Programmer-visible core register state with APB access and interrupt sequencing.
// Assumes an APB master, a vector memory read port answering combinationally
// from mem_addr while mem_rd is high, and level interrupt requests.
`timescale 1ns/100ps
`default_nettype none
module crs_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] irq_req,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic core_clk_en
);
    typedef struct packed {
        crs_pkg::crs_state_t state;
        logic [7:0] acc;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0] condition_code_reg;
        logic [15:0] data;
        logic [15:0] ea;
        logic [15:0] mem_addr;
        logic mem_rd;
        logic [2:0] pushed;
        logic [12:0] cnt;
        logic clk_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [255:0][7:0] stk;
    } crs_core_t;

    localparam crs_core_t CORE_RESET = '{
        state: crs_pkg::ST_VEC_HI,
        acc: 8'h00,
        hx: 16'h0000,
        sp: crs_pkg::SP_RESET,
        pc: 16'h0000,
        condition_code_reg: crs_pkg::CCR_RESET,
        data: 16'h0000,
        ea: 16'h0000,
        mem_addr: crs_pkg::RESET_VEC,
        mem_rd: 1'b1,
        pushed: 3'h0,
        cnt: 13'h0000,
        clk_en: 1'b1,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0,
        stk: '0
    };

    crs_core_t q;
    crs_core_t next_q;
    logic [7:0] alu_res;
    logic [7:0] alu_ccr;
    logic alu_wr;
    logic irq_any;
    logic [1:0] irq_idx;
    logic wr_fire;
    logic idle;
    logic take_irq;
    logic cmd_go;
    crs_pkg::crs_op_t cmd_op;

    // Known register offsets
    function automatic logic addr_ok(input logic [7:0] a);
        return (a <= crs_pkg::OFS_STATUS) && (a[1:0] == 2'b00);
    endfunction

    // Byte pushed at each step of interrupt entry
    function automatic logic [7:0] frame_byte(input logic [2:0] n, input crs_core_t s);
        case (n)
            3'h0: return s.pc[7:0];
            3'h1: return s.pc[15:8];
            3'h2: return s.hx[7:0];
            3'h3: return s.acc;
            default: return s.condition_code_reg;
        endcase
    endfunction

    // Stack byte a given distance above the stack pointer
    function automatic logic [7:0] pull_at(input crs_core_t s, input logic [7:0] d);
        logic [7:0] i;
        i = s.sp[7:0] + d;
        return s.stk[i];
    endfunction

    assign cmd_op = crs_pkg::crs_op_t'(pwdata[4:0]);

    crs_flag_alu crs_flag_alu_inst (
        .op(cmd_op),
        .a(q.acc),
        .m(q.data[7:0]),
        .ccr_in(q.condition_code_reg),
        .res(alu_res),
        .ccr_out(alu_ccr),
        .wr_acc(alu_wr)
    );

    crs_irq_pick crs_irq_pick_inst (
        .irq(irq_req),
        .any(irq_any),
        .idx(irq_idx)
    );

    // Bus handshake, command execution and sequencing
    always_comb
    begin
        next_q = q;
        next_q.pready = 1'b0;
        wr_fire = psel && penable && q.pready && pwrite && !q.pslverr;
        idle = (q.state == crs_pkg::ST_IDLE);
        take_irq = idle && irq_any && !q.condition_code_reg[crs_pkg::CCR_I];
        cmd_go = wr_fire && (paddr == crs_pkg::OFS_CMD) && idle && !take_irq;

        // Setup phase: capture read data, answer in the first access cycle
        if (psel && !penable && !q.pready)
        begin
            next_q.pready = 1'b1;
            next_q.pslverr = !addr_ok(paddr);
            case (paddr)
                crs_pkg::OFS_ACC: next_q.prdata = {24'h000000, q.acc};
                crs_pkg::OFS_INDEX: next_q.prdata = {16'h0000, q.hx};
                crs_pkg::OFS_SP: next_q.prdata = {16'h0000, q.sp};
                crs_pkg::OFS_PC: next_q.prdata = {16'h0000, q.pc};
                crs_pkg::OFS_CCR: next_q.prdata = {24'h000000, q.condition_code_reg | crs_pkg::CCR_FIXED};
                crs_pkg::OFS_DATA: next_q.prdata = {16'h0000, q.data};
                crs_pkg::OFS_EA: next_q.prdata = {16'h0000, q.ea};
                crs_pkg::OFS_STATUS: next_q.prdata = {24'h000000, 1'b0, q.state, 1'b0,
                    q.clk_en, (q.state == crs_pkg::ST_WAIT) || (q.state == crs_pkg::ST_STOP),
                    !idle};
                default: next_q.prdata = 32'h0000_0000;
            endcase
        end

        // Direct register loads, only while idle
        if (wr_fire && idle && !take_irq)
        begin
            case (paddr)
                crs_pkg::OFS_ACC: next_q.acc = pwdata[7:0];
                crs_pkg::OFS_INDEX: next_q.hx = pwdata[15:0];
                crs_pkg::OFS_SP: next_q.sp = pwdata[15:0];
                crs_pkg::OFS_PC: next_q.pc = pwdata[15:0];
                crs_pkg::OFS_CCR:
                begin
                    // A plain write may set the mask but never clear it
                    next_q.condition_code_reg = pwdata[7:0] | crs_pkg::CCR_FIXED;
                    next_q.condition_code_reg[crs_pkg::CCR_I] = pwdata[crs_pkg::CCR_I] | q.condition_code_reg[crs_pkg::CCR_I];
                end
                crs_pkg::OFS_DATA: next_q.data = pwdata[15:0];
                default: next_q.data = q.data;
            endcase
        end

        // Commands
        if (cmd_go)
        begin
            if (alu_wr)
            begin
                next_q.acc = alu_res;
                next_q.condition_code_reg = alu_ccr | crs_pkg::CCR_FIXED;
            end
            case (cmd_op)
                crs_pkg::OP_PUSH_A, crs_pkg::OP_PUSH_H:
                begin
                    next_q.stk[q.sp[7:0]] = (cmd_op == crs_pkg::OP_PUSH_A) ? q.acc : q.hx[15:8];
                    next_q.sp = q.sp - 16'h0001;
                end
                crs_pkg::OP_PULL_A:
                begin
                    next_q.acc = pull_at(q, 8'h01);
                    next_q.sp = q.sp + 16'h0001;
                end
                crs_pkg::OP_PULL_H:
                begin
                    next_q.hx[15:8] = pull_at(q, 8'h01);
                    next_q.sp = q.sp + 16'h0001;
                end
                crs_pkg::OP_RSP: next_q.sp = {q.sp[15:8], crs_pkg::RSP_LOW};
                crs_pkg::OP_CLI: next_q.condition_code_reg[crs_pkg::CCR_I] = 1'b0;
                crs_pkg::OP_SEI: next_q.condition_code_reg[crs_pkg::CCR_I] = 1'b1;
                crs_pkg::OP_RTI:
                begin
                    // Condition codes, accumulator, index low, then PC
                    next_q.condition_code_reg = pull_at(q, 8'h01) | crs_pkg::CCR_FIXED;
                    next_q.acc = pull_at(q, 8'h02);
                    next_q.hx[7:0] = pull_at(q, 8'h03);
                    next_q.pc = {pull_at(q, 8'h04), pull_at(q, 8'h05)};
                    next_q.sp = q.sp + 16'(crs_pkg::INT_FRAME_BYTES);
                end
                crs_pkg::OP_WAIT, crs_pkg::OP_STOP:
                begin
                    next_q.condition_code_reg[crs_pkg::CCR_I] = 1'b0;
                    next_q.clk_en = 1'b0;
                    next_q.state = (cmd_op == crs_pkg::OP_WAIT) ? crs_pkg::ST_WAIT
                        : crs_pkg::ST_STOP;
                end
                crs_pkg::OP_FETCH: next_q.pc = q.pc + 16'h0001;
                crs_pkg::OP_JUMP: next_q.pc = q.data;
                crs_pkg::OP_SP_EA: next_q.ea = q.sp + q.data;
                crs_pkg::OP_IX_EA: next_q.ea = q.hx + q.data;
                crs_pkg::OP_BGE:
                begin
                    // Signed branch taken when N xor V is clear
                    next_q.pc = q.pc + 16'h0002
                        + ((q.condition_code_reg[crs_pkg::CCR_N] ^ q.condition_code_reg[crs_pkg::CCR_V]) ? 16'h0000
                        : {{8{q.data[7]}}, q.data[7:0]});
                end
                default: next_q.pc = q.pc;
            endcase
        end

        // Sequencer
        case (q.state)
            crs_pkg::ST_IDLE:
            begin
                if (take_irq)
                begin
                    next_q.pushed = 3'h0;
                    next_q.ea = crs_pkg::IRQ_VEC_TOP - {13'h0000, irq_idx, 1'b0};
                    next_q.state = crs_pkg::ST_PUSH;
                end
            end
            crs_pkg::ST_PUSH:
            begin
                // Registers are saved before the mask is set
                next_q.stk[q.sp[7:0]] = frame_byte(q.pushed, q);
                next_q.sp = q.sp - 16'h0001;
                next_q.pushed = q.pushed + 3'h1;
                if (q.pushed == crs_pkg::INT_FRAME_BYTES - 3'h1)
                begin
                    next_q.condition_code_reg[crs_pkg::CCR_I] = 1'b1;
                    next_q.mem_addr = q.ea;
                    next_q.mem_rd = 1'b1;
                    next_q.state = crs_pkg::ST_VEC_HI;
                end
            end
            crs_pkg::ST_VEC_HI:
            begin
                next_q.pc[15:8] = mem_rdata;
                next_q.mem_addr = q.mem_addr + 16'h0001;
                next_q.state = crs_pkg::ST_VEC_LO;
            end
            crs_pkg::ST_VEC_LO:
            begin
                next_q.pc[7:0] = mem_rdata;
                next_q.mem_rd = 1'b0;
                next_q.state = crs_pkg::ST_IDLE;
            end
            crs_pkg::ST_WAIT:
            begin
                // Any request ends wait with the mask still clear
                if (irq_any)
                begin
                    next_q.clk_en = 1'b1;
                    next_q.pushed = 3'h0;
                    next_q.ea = crs_pkg::IRQ_VEC_TOP - {13'h0000, irq_idx, 1'b0};
                    next_q.state = crs_pkg::ST_PUSH;
                end
            end
            crs_pkg::ST_STOP:
            begin
                if (irq_any)
                begin
                    next_q.cnt = crs_pkg::STOP_RECOV_CYCLES - 13'h0001;
                    next_q.state = crs_pkg::ST_RECOV;
                end
            end
            crs_pkg::ST_RECOV:
            begin
                // Clock held off for the stabilization delay
                next_q.cnt = q.cnt - 13'h0001;
                if (q.cnt == 13'h0000)
                begin
                    next_q.clk_en = 1'b1;
                    next_q.pushed = 3'h0;
                    next_q.ea = crs_pkg::IRQ_VEC_TOP - {13'h0000, irq_idx, 1'b0};
                    next_q.state = crs_pkg::ST_PUSH;
                end
            end
            default: next_q.state = crs_pkg::ST_IDLE;
        endcase
    end

    // State register; reset sets the mask and starts the vector fetch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= CORE_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign mem_addr = q.mem_addr;
    assign mem_rd = q.mem_rd;
    assign core_clk_en = q.clk_en;

    // Checks
    AST_CCR_FIXED: assert property (@(posedge pclk) disable iff (!presetn)
        (q.condition_code_reg & crs_pkg::CCR_FIXED) == crs_pkg::CCR_FIXED)
        else $error("fixed condition code bits not one");

    AST_RSP_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd_op == crs_pkg::OP_RSP |=> q.sp == {$past(q.sp[15:8]), 8'hFF})
        else $error("reset stack command gave wrong stack pointer");

    AST_PUSH_DEC: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == crs_pkg::ST_PUSH |=> q.sp == $past(q.sp) - 16'h0001)
        else $error("stack pointer did not step down on push");

    AST_MASK_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(q.condition_code_reg[crs_pkg::CCR_I]) |-> $past(cmd_go) && ($past(cmd_op) == crs_pkg::OP_CLI
        || $past(cmd_op) == crs_pkg::OP_RTI || $past(cmd_op) == crs_pkg::OP_WAIT
        || $past(cmd_op) == crs_pkg::OP_STOP))
        else $error("interrupt mask cleared by other cause");

    AST_ENTRY_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        take_irq |=> !q.condition_code_reg[crs_pkg::CCR_I] [*5] ##1 q.condition_code_reg[crs_pkg::CCR_I]
        && q.state == crs_pkg::ST_VEC_HI && q.mem_rd)
        else $error("mask set out of order on interrupt entry");

    AST_MASK_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
        idle && q.condition_code_reg[crs_pkg::CCR_I] |=> q.state != crs_pkg::ST_PUSH)
        else $error("masked request started entry");

    AST_ZERO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd_op == crs_pkg::OP_ADD |=> q.condition_code_reg[crs_pkg::CCR_Z] == (q.acc == 8'h00))
        else $error("zero flag wrong after add");

    AST_WAIT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_go && cmd_op == crs_pkg::OP_WAIT |=> !q.clk_en && !q.condition_code_reg[crs_pkg::CCR_I]
        && q.state == crs_pkg::ST_WAIT)
        else $error("wait did not stop clock and clear mask");

    AST_VEC_PAIR: assert property (@(posedge pclk) disable iff (!presetn)
        q.state == crs_pkg::ST_VEC_HI |=> q.state == crs_pkg::ST_VEC_LO
        && q.mem_addr == $past(q.mem_addr) + 16'h0001 ##1 q.pc[7:0] == $past(mem_rdata))
        else $error("vector fetch pairing wrong");
endmodule // crs_core
`default_nettype wire

//--- crs_pkg.sv
// Constants and types shared by the core register state block.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
package crs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_INDEX = 8'h04;
    localparam logic [7:0] OFS_SP = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0C;
    localparam logic [7:0] OFS_CCR = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_DATA = 8'h18;
    localparam logic [7:0] OFS_EA = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // Condition code bit positions
    localparam int CCR_C = 0;
    localparam int CCR_Z = 1;
    localparam int CCR_N = 2;
    localparam int CCR_I = 3;
    localparam int CCR_H = 4;
    localparam int CCR_V = 7;
    localparam logic [7:0] CCR_FIXED = 8'h60;
    localparam logic [7:0] CCR_RESET = 8'h68;

    // Reset values and vectors
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [7:0] RSP_LOW = 8'hFF;
    localparam logic [15:0] RESET_VEC = 16'hFFFE;
    localparam logic [15:0] IRQ_VEC_TOP = 16'hFFFA;
    localparam int NUM_IRQ = 4;
    localparam logic [2:0] INT_FRAME_BYTES = 3'h5;

    // Stop recovery, in pclk cycles
    localparam logic [12:0] STOP_RECOV_CYCLES = 13'h1000;

    // Status register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_LOWPWR = 1;
    localparam int ST_CLKEN = 2;

    // Commands written to the command register
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_LOAD_A = 5'h01, OP_ADD = 5'h02, OP_ADC = 5'h03,
        OP_SUB = 5'h04, OP_AND = 5'h05, OP_ORA = 5'h06, OP_EOR = 5'h07,
        OP_ASL = 5'h08, OP_LSR = 5'h09, OP_DAA = 5'h0A, OP_PUSH_A = 5'h0B,
        OP_PULL_A = 5'h0C, OP_PUSH_H = 5'h0D, OP_PULL_H = 5'h0E, OP_RSP = 5'h0F,
        OP_CLI = 5'h10, OP_SEI = 5'h11, OP_RTI = 5'h12, OP_WAIT = 5'h13,
        OP_STOP = 5'h14, OP_FETCH = 5'h15, OP_JUMP = 5'h16, OP_SP_EA = 5'h17,
        OP_IX_EA = 5'h18, OP_BGE = 5'h19
    } crs_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_VEC_HI = 3'h1, ST_VEC_LO = 3'h2, ST_PUSH = 3'h3,
        ST_WAIT = 3'h4, ST_STOP = 3'h5, ST_RECOV = 3'h6
    } crs_state_t;

endpackage

//--- crs_flag_alu.sv
// Accumulator arithmetic and condition flag update.
// Assumes the caller writes res to the accumulator when wr_acc is high.
`timescale 1ns/100ps
`default_nettype none
module crs_flag_alu (
    input wire crs_pkg::crs_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] m,
    input wire logic [7:0] ccr_in,
    output logic [7:0] res,
    output logic [7:0] ccr_out,
    output logic wr_acc
);
    logic [8:0] sum;
    logic [4:0] hsum;
    logic cy;

    // Negative and zero follow the result
    function automatic logic [7:0] nz(input logic [7:0] c, input logic [7:0] r);
        logic [7:0] t;
        t = c;
        t[crs_pkg::CCR_N] = r[7];
        t[crs_pkg::CCR_Z] = (r == 8'h00);
        return t;
    endfunction

    // Flags not touched by an operation keep their value
    always_comb
    begin
        sum = 9'h000;
        hsum = 5'h00;
        cy = (op == crs_pkg::OP_ADC) ? ccr_in[crs_pkg::CCR_C] : 1'b0;
        res = a;
        ccr_out = ccr_in;
        wr_acc = 1'b1;
        case (op)
            crs_pkg::OP_ADD, crs_pkg::OP_ADC:
            begin
                sum = {1'b0, a} + {1'b0, m} + {8'h00, cy};
                hsum = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cy};
                res = sum[7:0];
                ccr_out = nz(ccr_in, res);
                ccr_out[crs_pkg::CCR_H] = hsum[4];
                ccr_out[crs_pkg::CCR_V] = (a[7] == m[7]) && (res[7] != a[7]);
                ccr_out[crs_pkg::CCR_C] = sum[8];
            end
            crs_pkg::OP_SUB:
            begin
                sum = {1'b0, a} - {1'b0, m};
                res = sum[7:0];
                ccr_out = nz(ccr_in, res);
                ccr_out[crs_pkg::CCR_V] = (a[7] != m[7]) && (res[7] != a[7]);
                ccr_out[crs_pkg::CCR_C] = sum[8];
            end
            crs_pkg::OP_AND, crs_pkg::OP_ORA, crs_pkg::OP_EOR, crs_pkg::OP_LOAD_A:
            begin
                res = (op == crs_pkg::OP_AND) ? (a & m) : (op == crs_pkg::OP_ORA) ? (a | m)
                    : (op == crs_pkg::OP_EOR) ? (a ^ m) : m;
                ccr_out = nz(ccr_in, res);
                ccr_out[crs_pkg::CCR_V] = 1'b0;
            end
            crs_pkg::OP_ASL:
            begin
                res = {a[6:0], 1'b0};
                ccr_out = nz(ccr_in, res);
                ccr_out[crs_pkg::CCR_C] = a[7];
                ccr_out[crs_pkg::CCR_V] = res[7] ^ a[7];
            end
            crs_pkg::OP_LSR:
            begin
                res = {1'b0, a[7:1]};
                ccr_out = nz(ccr_in, res);
                ccr_out[crs_pkg::CCR_C] = a[0];
                ccr_out[crs_pkg::CCR_V] = a[0];
            end
            crs_pkg::OP_DAA:
            begin
                // Decimal correction from half-carry and carry
                cy = ccr_in[crs_pkg::CCR_C] || (a > 8'h99);
                res = a + ((ccr_in[crs_pkg::CCR_H] || (a[3:0] > 4'h9)) ? 8'h06 : 8'h00)
                    + (cy ? 8'h60 : 8'h00);
                ccr_out = nz(ccr_in, res);
                ccr_out[crs_pkg::CCR_C] = cy;
            end
            default:
            begin
                wr_acc = 1'b0;
            end
        endcase
    end
endmodule // crs_flag_alu
`default_nettype wire

//--- crs_irq_pick.sv
// Picks the highest-priority pending interrupt request.
// Assumes request 0 has the highest priority and requests are levels.
`timescale 1ns/100ps
`default_nettype none
module crs_irq_pick (
    input wire logic [3:0] irq,
    output logic any,
    output logic [1:0] idx
);
    // Lowest index wins
    always_comb
    begin
        any = |irq;
        idx = 2'h0;
        for (int i = crs_pkg::NUM_IRQ - 1; i >= 0; i--)
        begin
            if (irq[i])
            begin
                idx = 2'(i);
            end
        end
    end
endmodule // crs_irq_pick
`default_nettype wire

//--- crs_core_tb.sv
// Self-checking bench for the core register state block.
// Assumes the APB slave answers without wait states and a combinational vector memory.
`timescale 1ns/100ps
`default_nettype none
module crs_core_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sv, mem_rd, core_clk_en;
    logic [3:0] irq_req = 4'h0;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata;
    int n_fail = 0, samples_checked = 0;
    // Vector memory returns the low address byte
    assign mem_rdata = mem_addr[7:0];
    always #12.5 pclk = ~pclk;
    crs_core crs_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_req(irq_req), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .core_clk_en(core_clk_en));
    // One APB transfer, entered just after a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // One idle edge keeps the previous release apart from this request
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            n_fail++;
            $display("wrong value at %0t: bus answer timed out", $time);
        end
        rd = prdata;
        sv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task cmd(input crs_pkg::crs_op_t op);
        xfer(1'b1, crs_pkg::OFS_CMD, {27'h0, op});
    endtask
    // Address forming, program counter moves, index high stacking and stop exit
    task t_more;
        xfer(1'b1, crs_pkg::OFS_INDEX, 32'h1234);
        xfer(1'b1, crs_pkg::OFS_DATA, 32'h0010);
        cmd(crs_pkg::OP_IX_EA);
        rdc(crs_pkg::OFS_EA, 32'h1244);
        xfer(1'b1, crs_pkg::OFS_SP, 32'h0100);
        cmd(crs_pkg::OP_SP_EA);
        rdc(crs_pkg::OFS_EA, 32'h0110);
        xfer(1'b1, crs_pkg::OFS_PC, 32'h1000);
        cmd(crs_pkg::OP_FETCH);
        rdc(crs_pkg::OFS_PC, 32'h1001);
        cmd(crs_pkg::OP_JUMP);
        rdc(crs_pkg::OFS_PC, 32'h0010);
        cmd(crs_pkg::OP_PUSH_H);
        xfer(1'b1, crs_pkg::OFS_INDEX, 32'h0034);
        cmd(crs_pkg::OP_PULL_H);
        rdc(crs_pkg::OFS_INDEX, 32'h1234);
        rdc(crs_pkg::OFS_SP, 32'h0100);
        cmd(crs_pkg::OP_BGE);
        rdc(crs_pkg::OFS_PC, 32'h0012);
        rdc(crs_pkg::OFS_CCR, 32'hEB);
        $display("address test done");
        cmd(crs_pkg::OP_STOP);
        repeat (4090) @(posedge pclk);
        chk(core_clk_en, 1'b0);
        repeat (20) @(posedge pclk);
        chk(core_clk_en, 1'b1);
        rdc(crs_pkg::OFS_CCR, 32'hEB);
        $display("stop test done");
    endtask
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(crs_pkg::OFS_SP, 32'h00FF);
        rdc(crs_pkg::OFS_CCR, 32'h68);
        rdc(crs_pkg::OFS_PC, 32'hFEFF);
        xfer(1'b0, 8'h24, 32'h0);
        chk(sv, 1'b1);
        $display("reset test done");
        xfer(1'b1, crs_pkg::OFS_SP, 32'h1234);
        cmd(crs_pkg::OP_RSP);
        rdc(crs_pkg::OFS_SP, 32'h12FF);
        xfer(1'b1, crs_pkg::OFS_SP, 32'h00F0);
        cmd(crs_pkg::OP_PUSH_A);
        rdc(crs_pkg::OFS_SP, 32'h00EF);
        cmd(crs_pkg::OP_PULL_A);
        rdc(crs_pkg::OFS_SP, 32'h00F0);
        $display("stack test done");
        xfer(1'b1, crs_pkg::OFS_DATA, 32'h7F);
        cmd(crs_pkg::OP_LOAD_A);
        xfer(1'b1, crs_pkg::OFS_DATA, 32'h01);
        cmd(crs_pkg::OP_ADD);
        rdc(crs_pkg::OFS_ACC, 32'h80);
        rdc(crs_pkg::OFS_CCR, 32'hFC);
        xfer(1'b1, crs_pkg::OFS_DATA, 32'h80);
        cmd(crs_pkg::OP_ADD);
        rdc(crs_pkg::OFS_CCR, 32'hEB);
        $display("flag test done");
        irq_req <= 4'h6;
        repeat (10) @(posedge pclk);
        rdc(crs_pkg::OFS_PC, 32'hFEFF);
        cmd(crs_pkg::OP_CLI);
        repeat (15) @(posedge pclk);
        rdc(crs_pkg::OFS_PC, 32'hF8F9);
        rdc(crs_pkg::OFS_SP, 32'h00EB);
        rdc(crs_pkg::OFS_CCR, 32'hEB);
        irq_req <= 4'h0;
        cmd(crs_pkg::OP_RTI);
        rdc(crs_pkg::OFS_SP, 32'h00F0);
        rdc(crs_pkg::OFS_CCR, 32'hE3);
        rdc(crs_pkg::OFS_PC, 32'hFEFF);
        $display("interrupt test done");
        cmd(crs_pkg::OP_SEI);
        cmd(crs_pkg::OP_WAIT);
        repeat (2) @(posedge pclk);
        chk(core_clk_en, 1'b0);
        rdc(crs_pkg::OFS_CCR, 32'hE3);
        irq_req <= 4'h1;
        repeat (15) @(posedge pclk);
        chk(core_clk_en, 1'b1);
        rdc(crs_pkg::OFS_PC, 32'hFAFB);
        $display("wait test done");
        t_more;
        final_report;
    end
    // Watchdog cuts a hung run short
    initial
    begin
        #(25 * 8000);
        n_fail++;
        final_report;
    end
endmodule // crs_core_tb
`default_nettype wire
